// *** hw/phy_event_pkg.sv ***
package phy_event_pkg;

	// ----------------------------------------------------------------
	// Register map (5-bit management register address)
	// ----------------------------------------------------------------
	localparam logic [4:0]  ADDR_INT_TEST   = 5'h11;
	localparam logic [4:0]  ADDR_STAT_EN    = 5'h12;
	localparam logic [4:0]  ADDR_FC_COUNT   = 5'h14;
	localparam logic [4:0]  ADDR_RXERR_CNT  = 5'h15;

	// ----------------------------------------------------------------
	// Field positions in interrupt_status_enable_one
	// ----------------------------------------------------------------
	localparam int          STAT_LSB        = 8;   // Flags sit in bits 15:8
	localparam int          NUM_EVENTS      = 8;
	localparam int          BIT_LQ_FLAG     = 15;
	localparam int          BIT_ED_FLAG     = 14;
	localparam int          BIT_LS_FLAG     = 13;
	localparam int          BIT_WAKE_FLAG   = 12;
	localparam int          BIT_ESD_FLAG    = 11;
	localparam int          BIT_MST_FLAG    = 10;
	localparam int          BIT_FC_FLAG     = 9;
	localparam int          BIT_RXE_FLAG    = 8;

	// Fields of the interrupt test register
	localparam int          BIT_POLARITY    = 3;
	localparam int          BIT_TEST_INT    = 2;

	// ----------------------------------------------------------------
	// Reset values and counter limits
	// ----------------------------------------------------------------
	localparam logic [7:0]  ENABLE_RESET    = 8'h00;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;
	localparam logic        POLARITY_RESET  = 1'b1;
	localparam logic        TEST_INT_RESET  = 1'b0;
	localparam logic [7:0]  FC_HALF_FULL    = 8'h7f;
	localparam logic [7:0]  FC_MAX          = 8'hff;
	localparam logic [15:0] RXE_HALF_FULL   = 16'h7fff;
	localparam logic [15:0] RXE_MAX         = 16'hffff;
	localparam logic [15:0] READ_ZERO       = 16'h0000;
	localparam logic        LINE_RESET      = 1'b0;
	localparam logic [7:0]  FC_CNT_RESET    = 8'h00;
	localparam logic [15:0] RXE_CNT_RESET   = 16'h0000;

endpackage

// *** hw/phy_event_status_mask_reg.sv ***
`timescale 1ns/1ps
module phy_event_status_mask_reg (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        link_up,
	input  wire logic        link_quality_good,
	input  wire logic        energy_detect,
	input  wire logic        wake_frame,
	input  wire logic        esd_event,
	input  wire logic        master_slave_training,
	input  wire logic        false_carrier,
	input  wire logic        receive_error,
	output logic             int_pin
);

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic        rst_meta_q;
	logic        rst_n_q;

	// Release is synchronous so no flop sees a partial reset edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic        wr_stat;
	logic        rd_stat;
	logic        wr_test;
	logic        rd_fc;
	logic        rd_rxe;

	assign wr_stat = reg_wr && (reg_addr == phy_event_pkg::ADDR_STAT_EN);
	assign rd_stat = reg_rd && (reg_addr == phy_event_pkg::ADDR_STAT_EN);
	assign wr_test = reg_wr && (reg_addr == phy_event_pkg::ADDR_INT_TEST);
	assign rd_fc   = reg_rd && (reg_addr == phy_event_pkg::ADDR_FC_COUNT);
	assign rd_rxe  = reg_rd && (reg_addr == phy_event_pkg::ADDR_RXERR_CNT);

	// ----------------------------------------------------------------
	// Previous line states for change detection
	// ----------------------------------------------------------------
	logic        link_up_q;
	logic        link_up_chg;
	logic        lq_good_chg;
	logic        energy_chg;

	// One detector per level line; a link_up or energy_detect line high straight after reset
	// reports one change, which software clears with its first read
	level_change_detect #(
		.RESET_VAL (phy_event_pkg::LINE_RESET)
	) link_up_change_i (
		.sys_clk (sys_clk),
		.rst_n   (rst_n_q),
		.level   (link_up),
		.level_q (link_up_q),
		.changed (link_up_chg)
	);

	level_change_detect #(
		.RESET_VAL (phy_event_pkg::LINE_RESET)
	) lq_good_change_i (
		.sys_clk (sys_clk),
		.rst_n   (rst_n_q),
		.level   (link_quality_good),
		.level_q (),
		.changed (lq_good_chg)
	);

	level_change_detect #(
		.RESET_VAL (phy_event_pkg::LINE_RESET)
	) energy_change_i (
		.sys_clk (sys_clk),
		.rst_n   (rst_n_q),
		.level   (energy_detect),
		.level_q (),
		.changed (energy_chg)
	);

	// ----------------------------------------------------------------
	// Event counters
	// ----------------------------------------------------------------
	logic [7:0]  fc_cnt_q;
	logic [15:0] rxe_cnt_q;
	logic        fc_half_evt;
	logic        rxe_half_evt;

	// False-carrier count: 8 bits, crossing event past the midpoint,
	// held at the top so a long burst cannot wrap into a second crossing
	sat_event_counter #(
		.WIDTH     (8),
		.HALF_FULL (phy_event_pkg::FC_HALF_FULL),
		.MAX_COUNT (phy_event_pkg::FC_MAX),
		.RESET_VAL (phy_event_pkg::FC_CNT_RESET)
	) fc_counter_i (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n_q),
		.count_evt (false_carrier),
		.clear_rd  (rd_fc),
		.count_q   (fc_cnt_q),
		.half_evt  (fc_half_evt)
	);

	// Receive-error count, same behaviour on a 16-bit range
	sat_event_counter #(
		.WIDTH     (16),
		.HALF_FULL (phy_event_pkg::RXE_HALF_FULL),
		.MAX_COUNT (phy_event_pkg::RXE_MAX),
		.RESET_VAL (phy_event_pkg::RXE_CNT_RESET)
	) rxe_counter_i (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n_q),
		.count_evt (receive_error),
		.clear_rd  (rd_rxe),
		.count_q   (rxe_cnt_q),
		.half_evt  (rxe_half_evt)
	);

	// ----------------------------------------------------------------
	// Event sources, one per flag
	// ----------------------------------------------------------------
	logic [7:0]  evt;

	always_comb begin
		evt = 8'h00;
		evt[phy_event_pkg::BIT_LQ_FLAG - phy_event_pkg::STAT_LSB] =
			link_up && link_up_q && lq_good_chg;
		evt[phy_event_pkg::BIT_ED_FLAG - phy_event_pkg::STAT_LSB] =
			energy_chg;
		evt[phy_event_pkg::BIT_LS_FLAG - phy_event_pkg::STAT_LSB] =
			link_up_chg;
		evt[phy_event_pkg::BIT_WAKE_FLAG - phy_event_pkg::STAT_LSB] = wake_frame;
		evt[phy_event_pkg::BIT_ESD_FLAG - phy_event_pkg::STAT_LSB]  = esd_event;
		evt[phy_event_pkg::BIT_MST_FLAG - phy_event_pkg::STAT_LSB]  =
			master_slave_training;
		evt[phy_event_pkg::BIT_FC_FLAG - phy_event_pkg::STAT_LSB]   = fc_half_evt;
		evt[phy_event_pkg::BIT_RXE_FLAG - phy_event_pkg::STAT_LSB]  = rxe_half_evt;
	end

	// ----------------------------------------------------------------
	// Latched flags and enables
	// ----------------------------------------------------------------
	logic [7:0]  flags_q;
	logic [7:0]  enable_q;
	logic        polarity_q;
	logic        test_int_q;

	// One sticky cell per event bit, all cleared by the same status read
	for (genvar i = 0; i < phy_event_pkg::NUM_EVENTS; i++) begin : g_flag
		sticky_flag #(
			.RESET_VAL (phy_event_pkg::FLAGS_RESET[i])
		) flag_i (
			.sys_clk  (sys_clk),
			.rst_n    (rst_n_q),
			.set_evt  (evt[i]),
			.clear_rd (rd_stat),
			.flag_q   (flags_q[i])
		);
	end

	// Enables live in the low byte; flag bits ignore writes
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			enable_q <= phy_event_pkg::ENABLE_RESET;
		end else if (wr_stat) begin
			enable_q <= reg_wdata[7:0];
		end
	end

	// Polarity and forced-interrupt controls
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			polarity_q <= phy_event_pkg::POLARITY_RESET;
			test_int_q <= phy_event_pkg::TEST_INT_RESET;
		end else if (wr_test) begin
			polarity_q <= reg_wdata[phy_event_pkg::BIT_POLARITY];
			test_int_q <= reg_wdata[phy_event_pkg::BIT_TEST_INT];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	logic        int_active;

	assign int_active = (|(flags_q & enable_q)) || test_int_q;

	// Registered so the pin never glitches on decode paths
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			int_pin <= phy_event_pkg::POLARITY_RESET;
		end else begin
			int_pin <= polarity_q ? !int_active : int_active;
		end
	end

	// ----------------------------------------------------------------
	// Read data, valid the cycle after the strobe
	// ----------------------------------------------------------------
	logic [15:0] rdata_d;

	always_comb begin
		rdata_d = phy_event_pkg::READ_ZERO;
		if (rd_stat) begin
			rdata_d = {flags_q, enable_q};
		end else if (reg_rd && (reg_addr == phy_event_pkg::ADDR_INT_TEST)) begin
			rdata_d[phy_event_pkg::BIT_POLARITY] = polarity_q;
			rdata_d[phy_event_pkg::BIT_TEST_INT] = test_int_q;
		end else if (rd_fc) begin
			rdata_d = {8'h00, fc_cnt_q};
		end else if (rd_rxe) begin
			rdata_d = rxe_cnt_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= phy_event_pkg::READ_ZERO;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

endmodule

// ----------------------------------------------------------------
// Saturating event counter, cleared by a read of its register
// ----------------------------------------------------------------
module sat_event_counter #(
	parameter int               WIDTH     = 8,
	parameter logic [WIDTH-1:0] HALF_FULL = '0,
	parameter logic [WIDTH-1:0] MAX_COUNT = '1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             count_evt,
	input  wire logic             clear_rd,
	output logic      [WIDTH-1:0] count_q,
	output logic                  half_evt
);

	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

	logic [WIDTH-1:0] count_d;

	// A read clears, but an event in that cycle counts as one so none is lost
	always_comb begin
		count_d = count_q;
		if (clear_rd) begin
			count_d = count_evt ? ONE : RESET_VAL;
		end else if (count_evt && (count_q != MAX_COUNT)) begin
			count_d = count_q + ONE;
		end
	end

	// Holding at the top stops a wrap from faking a second crossing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= RESET_VAL;
		end else begin
			count_q <= count_d;
		end
	end

	// Fires once, on the step past the midpoint; a read rearms it
	assign half_evt = (count_q == HALF_FULL) && (count_d > HALF_FULL);

endmodule

// ----------------------------------------------------------------
// Change detector for one level line
// ----------------------------------------------------------------
module level_change_detect #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      level_q,
	output logic      changed
);

	// History starts at the idle level so reset makes no false edge on a quiet line
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= RESET_VAL;
		end else begin
			level_q <= level;
		end
	end

	// Either edge counts, as both directions of a level change matter
	assign changed = level != level_q;

endmodule

// ----------------------------------------------------------------
// Latched-high status cell
// ----------------------------------------------------------------
module sticky_flag #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic set_evt,
	input  wire logic clear_rd,
	output logic      flag_q
);

	// Set beats clear: an event in the read cycle waits for the next read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= RESET_VAL;
		end else begin
			flag_q <= set_evt || (flag_q && !clear_rd);
		end
	end

endmodule

// *** sim/phy_event_status_mask_reg_props.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker
// ------------------------------------------------
module phy_event_props (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        link_up,
	input wire logic        wake_frame,
	input wire logic        esd_event,
	input wire logic        master_slave_training
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// A status read; flags clear at its edge
	sequence rd_stat;
		reg_rd && reg_addr == phy_event_pkg::ADDR_STAT_EN;
	endsequence
	// Two quiet cycles keep the latched flag, then a read
	sequence late_rd;
		!reg_rd [*2] ##1 rd_stat;
	endsequence
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
	unmapped_read_a: assert property (reg_rd && reg_addr == 5'h1f |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	wake_flag_a: assert property (wake_frame ##1 late_rd |=> reg_rdata[12])
		else $error("wake flag missing");
	esd_flag_a: assert property (esd_event ##1 late_rd |=> reg_rdata[11])
		else $error("discharge flag missing");
	train_flag_a: assert property (master_slave_training ##1 late_rd |=> reg_rdata[10])
		else $error("training flag missing");
	link_flag_a: assert property ($changed(link_up) ##1 late_rd |=> reg_rdata[13])
		else $error("link flag missing");
	read_clear_a: assert property ((!esd_event throughout rd_stat) ##1 rd_stat |=> !reg_rdata[11])
		else $error("flag kept after read");
	enable_rw_a: assert property (reg_wr && reg_addr == phy_event_pkg::ADDR_STAT_EN ##1 rd_stat
		|=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
		else $error("enable readback wrong");
endmodule
bind phy_event_status_mask_reg phy_event_props phy_event_props_i (.sys_clk, .arst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .wake_frame, .esd_event,
	.master_slave_training);

// *** sim/phy_event_status_mask_reg_test.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Bench
// ------------------------------------------------
module phy_event_status_mask_reg_test;
	logic        sys_clk, arst_n, reg_wr, reg_rd, int_pin, link_up, link_quality_good;
	logic        energy_detect, wake_frame, esd_event, master_slave_training;
	logic        false_carrier, receive_error;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [7:0]  en;
	int          fails, samples_checked, cycles;
	phy_event_status_mask_reg phy_event_status_mask_reg_i (.sys_clk, .arst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .link_quality_good, .energy_detect,
		.wake_frame, .esd_event, .master_slave_training, .false_carrier, .receive_error, .int_pin);
	// Clock and a hang guard sized well above the receive-error run
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 50000) begin
			fails++;
			conclude();
		end
	end
	function automatic logic [15:0] stat(input int k);
		return (16'h0001 << k) | {8'h00, en};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Bus tasks start and end just after an edge; back-to-back reads test clear-on-read
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd2(input logic [4:0] a, input logic [15:0] e1, input logic [15:0] e2);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		#1 chk(reg_rdata, e1);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e2);
		@(posedge sys_clk);
	endtask
	// Levels toggle once; pulse inputs stay high for n cycles, one event each
	task automatic fire(input int k, input int n);
		case (k)
			15: link_quality_good <= ~link_quality_good;
			14: energy_detect <= ~energy_detect;
			13: link_up <= ~link_up;
			12: wake_frame <= 1'b1;
			11: esd_event <= 1'b1;
			10: master_slave_training <= 1'b1;
			9: false_carrier <= 1'b1;
			default: receive_error <= 1'b1;
		endcase
		repeat (n) @(posedge sys_clk);
		{wake_frame, esd_event, master_slave_training, false_carrier, receive_error} <= 5'h00;
	endtask
	task automatic ev(input int k, input int n);
		logic hit;
		hit = k != 15 || link_up === 1'b1;
		fire(k, n);
		@(posedge sys_clk);
		#1 chk({15'h0000, int_pin}, {15'h0000, !(hit && en[k-8])});
		@(posedge sys_clk);
		rd2(5'h12, hit ? stat(k) : {8'h00, en}, {8'h00, en});
		#1 chk({15'h0000, int_pin}, 16'h0001);
		@(posedge sys_clk);
	endtask
	// Reset, then each event under random enables and their inverse, link quality raised only under the random set, receive error once under the inverse only
	initial begin
		arst_n = 1'b0;
		{reg_wr, reg_rd, link_up, link_quality_good, energy_detect} = 5'h00;
		{wake_frame, esd_event, master_slave_training, false_carrier, receive_error} = 5'h00;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		void'($urandom(13));
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		en = 8'h00;
		chk({15'h0000, int_pin}, 16'h0001);
		rd2(phy_event_pkg::ADDR_STAT_EN, 16'h0000, 16'h0000);
		rd2(phy_event_pkg::ADDR_INT_TEST, 16'h0008, 16'h0008);
		rd2(5'h1f, 16'h0000, 16'h0000);
		for (int p = 0; p < 2; p++) begin
			en = p == 0 ? 8'($urandom) : ~en;
			wr(phy_event_pkg::ADDR_STAT_EN, {8'($urandom), en});
			rd2(5'h12, {8'h00, en}, {8'h00, en});
			for (int k = 10; k < 16; k++) ev(k, 1);
			fire(9, 127);
			rd2(5'h12, {8'h00, en}, {8'h00, en});
			ev(9, 1);
			rd2(phy_event_pkg::ADDR_FC_COUNT, 16'h0080, 16'h0000);
			fire(9, 300);
			rd2(phy_event_pkg::ADDR_FC_COUNT, 16'h00ff, 16'h0000);
			rd2(5'h12, stat(9), {8'h00, en});
		end
		fire(8, 32767);
		rd2(5'h12, {8'h00, en}, {8'h00, en});
		ev(8, 1);
		rd2(phy_event_pkg::ADDR_RXERR_CNT, 16'h8000, 16'h0000);
		wr(phy_event_pkg::ADDR_INT_TEST, 16'h0000);
		repeat (2) @(posedge sys_clk);
		#1 chk({15'h0000, int_pin}, 16'h0000);
		@(posedge sys_clk);
		wr(phy_event_pkg::ADDR_INT_TEST, 16'h0004);
		rd2(phy_event_pkg::ADDR_INT_TEST, 16'h0004, 16'h0004);
		#1 chk({15'h0000, int_pin}, 16'h0001);
		conclude();
	end
endmodule
